// >>> shared/term_map_pkg.sv
// Purpose: Shared constants and types for the input terminal function mapper
// Assumes: Classic Wishbone register access, 32-bit data, word-aligned offsets
// Notes:   Offsets are byte addresses; every register occupies one aligned word
package term_map_pkg;

   // Terminal and selector geometry
   localparam int NUM_TERMS = 10;
   localparam int SEL_W = 6;
   localparam int NUM_FUNCS = 64;

   // Register byte offsets
   localparam logic [7:0] OFF_SEL_BASE = 8'h00; // Ten selectors, one word each
   localparam logic [7:0] OFF_CONFIG = 8'h28;
   localparam logic [7:0] OFF_HITS_LO = 8'h2c;
   localparam logic [7:0] OFF_HITS_HI = 8'h30;
   localparam logic [7:0] OFF_EVENT_CNT = 8'h34;
   localparam logic [7:0] OFF_LENGTH_CNT = 8'h38;
   localparam logic [7:0] OFF_UPDN_TRIM = 8'h3c;
   localparam logic [7:0] OFF_CMD_SRC = 8'h40;

   // Selector reset values, terminal 1 first
   localparam logic [SEL_W-1:0] SEL_RESET [NUM_TERMS] = '{
      6'h01, 6'h02, 6'h10, 6'h11, 6'h12, 6'h00, 6'h00, 6'h00, 6'h00, 6'h00};

   // Terminal index of the fast pulse terminal (seventh terminal)
   localparam int FAST_PULSE_TERM = 6;

   // Config register fields
   localparam int CFG_SRC_LSB = 0;  // run_command_source, 2 bits
   localparam int CFG_REFSW_LSB = 2; // reference_switch_option ones place, 4 bits
   localparam int CFG_GAINSW_LSB = 6; // pid_gain_switch_mode, 2 bits
   localparam int CFG_UPDN_BIT = 8;  // Digital plus up/down channel selected
   localparam logic [8:0] CONFIG_RESET = 9'h001;

   // Run command sources, and the gain switch mode chosen by terminal
   localparam logic [1:0] SRC_KEYPAD = 2'h0;
   localparam logic [1:0] SRC_TERMINAL = 2'h1;
   localparam logic [1:0] SRC_COMM = 2'h2;
   localparam logic [1:0] GAIN_SWITCH_BY_TERM = 2'h2;

   // Function codes
   localparam int FN_NONE = 0;
   localparam int FN_FWD_RUN = 1;
   localparam int FN_REV_RUN = 2;
   localparam int FN_FWD_INCH = 3;
   localparam int FN_REV_INCH = 4;
   localparam int FN_THREE_WIRE = 5;
   localparam int FN_COAST = 6;
   localparam int FN_EMERG = 7;
   localparam int FN_EXT_STOP = 8;
   localparam int FN_RUN_INHIBIT = 9;
   localparam int FN_RUN_PAUSE = 10;
   localparam int FN_EXT_FAULT = 11;
   localparam int FN_FAULT_RESET = 12;
   localparam int FN_UP = 13;
   localparam int FN_DOWN = 14;
   localparam int FN_UPDN_CLR = 15;
   localparam int FN_STEP0 = 16;
   localparam int FN_ACC0 = 20;
   localparam int FN_ACC_HOLD = 22;
   localparam int FN_SRC_KEYPAD = 23;
   localparam int FN_SRC_TERM = 24;
   localparam int FN_SRC_COMM = 25;
   localparam int FN_REF_SWITCH = 26;
   localparam int FN_MAIN_DIGITAL = 27;
   localparam int FN_AUX_DIGITAL = 28;
   localparam int FN_DCB_STOP_CMD = 29;
   localparam int FN_DCB_STOP = 30;
   localparam int FN_DCB_START = 31;
   localparam int FN_PULSE_REF = 32;
   localparam int FN_COUNT_IN = 33;
   localparam int FN_COUNT_CLR = 34;
   localparam int FN_LENGTH_IN = 35;
   localparam int FN_LENGTH_CLR = 36;
   localparam int FN_PID_INVERT = 37;
   localparam int FN_PID_GAIN2 = 38;
   localparam int FN_PID_HOLD = 39;
   localparam int FN_PID_INT_HOLD = 40;
   localparam int FN_SEQ_RESET = 41;
   localparam int FN_SEQ_DISABLE = 42;

   // Requests handed to the motion core
   typedef struct packed {
      logic forward_run_cmd;
      logic reverse_run_cmd;
      logic forward_inch_cmd;
      logic reverse_inch_cmd;
      logic inch_stop;
      logic three_wire;
      logic coast_stop;
      logic emerg_stop;
      logic ext_stop;
      logic run_inhibit;
      logic run_pause;
      logic external_fault_indication;
      logic fault_reset;
      logic updn_clear;
      logic [3:0] speed_index;
      logic [1:0] accel_index;
      logic accel_hold;
      logic ref_switch;
      logic main_digital;
      logic aux_digital;
      logic dcb_stop_cmd;
      logic dcb_stop;
      logic dcb_start;
      logic pulse_ref;
      logic pulse_ref_fast;
      logic pid_invert;
      logic pid_gain2;
      logic pid_hold;
      logic pid_int_hold;
      logic seq_reset;
      logic seq_disable;
      logic seq_restart;
      logic [1:0] cmd_src;
   } req_t;

endpackage

// >>> rtl/input_terminal_function_mapper.sv
// Purpose: Decode ten input terminals through per-terminal function selectors
// Assumes: Terminal levels already synchronous to MCLK, high means on
// Notes:   Functions 43 and up, polarity, filtering and delays are absent
//
// Functional notes
// - Selector code 00 yields no request regardless of the terminal level.
// - Codes 01 and 02 request forward or reverse run while on.
// - Inch: only forward on is forward, only reverse on is reverse, both on is stop.
// - Codes 01 to 05 act only when the command source is terminal.
// - Code 06 coasts to stop; code 08 stops by configured stop mode.
// - Code 07 decelerates to stop with the emergency decel time.
// - Code 09 on blocks every start command; drive stays stopped.
// - Code 10 holds zero frequency while on, resumes when off.
// - Code 11 on raises the external fault indication.
// - Code 12 clears an active fault like the keypad stop key.
// - Codes 13/14 trim frequency on up/down channel; 15 clears all trim.
// - Codes 16 to 19 form a 4-bit speed index, code 16 the LSB.
// - Codes 20 and 21 form a 2-bit accel/decel pair index.
// - Code 22 freezes output frequency while on.
// - Codes 23, 24, 25 switch command source to keypad, terminal, comm.
// - Code 26 switches reference channel; 27 and 28 force digital settings.
// - Code 29 starts decel stop, then DC braking below threshold.
// - Code 30 enables stop-stage DC braking on a stop command.
// - Code 31 makes a start brake by DC first, then start.
// - Code 32 is pulse reference, fast only on terminal 7; 33-36 count/length.
// - Codes 37 to 40 invert, switch gains, hold output, freeze PID integrator.
// - Code 41 resets the sequencer; 42 clears it, restarts when released.
//
// Chosen here: the register offsets and the Wishbone slave port.
module input_terminal_function_mapper #(
   parameter int CNT_W = 32, // Width of event and length counters
   parameter int TRIM_W = 16 // Width of the signed up/down trim
) (
   input wire logic MCLK, // System clock, 20 MHz
   input wire logic RST_N, // Synchronous reset, active low
   input wire logic CYC_I, // Wishbone cycle
   input wire logic STB_I, // Wishbone strobe
   input wire logic WE_I, // Wishbone write enable
   input wire logic [7:0] ADR_I, // Wishbone byte address
   input wire logic [3:0] SEL_I, // Wishbone byte lanes
   input wire logic [31:0] DAT_I, // Wishbone write data
   output logic [31:0] DAT_O, // Wishbone read data
   output logic ACK_O, // Wishbone acknowledge
   input wire logic [term_map_pkg::NUM_TERMS-1:0] TERM_IN, // Terminal on levels
   output term_map_pkg::req_t CMD, // Requests to the motion core
   output logic [CNT_W-1:0] EVENT_COUNT, // Count input total
   output logic [CNT_W-1:0] LENGTH_COUNT, // Length input total
   output logic signed [TRIM_W-1:0] UPDN_TRIM // Accumulated up/down trim
);

   // Function hit vector: bit k is high when any on terminal selects code k; bit 0 (code 00) stays low
   function automatic logic [term_map_pkg::NUM_FUNCS-1:0] decode_hits(
      input logic [term_map_pkg::SEL_W-1:0] sel [term_map_pkg::NUM_TERMS],
      input logic [term_map_pkg::NUM_TERMS-1:0] on);
      logic [term_map_pkg::NUM_FUNCS-1:0] hits;
      hits = '0;
      for (int t = 0; t < term_map_pkg::NUM_TERMS; t++) begin
         if (on[t]) begin
            hits[sel[t]] = 1'b1;
         end
      end
      hits[term_map_pkg::FN_NONE] = 1'b0;
      return hits;
   endfunction

   // Byte-lane merge of a write into a stored word
   function automatic logic [31:0] merge_lanes(input logic [31:0] old, input logic [31:0] wd,
                                               input logic [3:0] sel);
      logic [31:0] res;
      res = old;
      for (int b = 0; b < 4; b++) begin
         if (sel[b]) begin
            res[8*b +: 8] = wd[8*b +: 8];
         end
      end
      return res;
   endfunction

   logic [term_map_pkg::SEL_W-1:0] sel_r [term_map_pkg::NUM_TERMS];
   logic [8:0] config_r;
   logic ack_r;
   logic [31:0] dat_r;
   logic [term_map_pkg::NUM_FUNCS-1:0] hits;
   logic [term_map_pkg::NUM_FUNCS-1:0] hits_prev_r;
   logic [term_map_pkg::NUM_FUNCS-1:0] rise;
   logic [term_map_pkg::NUM_FUNCS-1:0] fall;
   logic [1:0] src_nxt;
   logic term_mode;
   logic updn_active;
   logic fast_pulse;
   logic [CNT_W-1:0] event_r;
   logic [CNT_W-1:0] length_r;
   logic signed [TRIM_W-1:0] trim_r;
   logic signed [TRIM_W-1:0] trim_nxt;
   term_map_pkg::req_t cmd_r;
   term_map_pkg::req_t cmd_nxt;
   logic bus_req;
   logic bus_wr;

   // Decode and edge detect; inputs are taken as already synchronous
   assign hits = decode_hits(sel_r, TERM_IN);
   assign rise = hits & ~hits_prev_r;
   assign fall = ~hits & hits_prev_r;

   always_ff @(posedge MCLK) begin
      if (!RST_N) begin
         hits_prev_r <= '0;
      end else begin
         hits_prev_r <= hits;
      end
   end

   // Effective command source: terminal overrides in keypad, terminal, comm priority
   always_comb begin
      if (hits[term_map_pkg::FN_SRC_KEYPAD]) begin
         src_nxt = term_map_pkg::SRC_KEYPAD;
      end else if (hits[term_map_pkg::FN_SRC_TERM]) begin
         src_nxt = term_map_pkg::SRC_TERMINAL;
      end else if (hits[term_map_pkg::FN_SRC_COMM]) begin
         src_nxt = term_map_pkg::SRC_COMM;
      end else begin
         src_nxt = config_r[term_map_pkg::CFG_SRC_LSB +: 2];
      end
   end

   assign term_mode = (src_nxt == term_map_pkg::SRC_TERMINAL);
   assign updn_active = config_r[term_map_pkg::CFG_UPDN_BIT];
   // Fast pulse operation exists only on the seventh terminal
   assign fast_pulse = TERM_IN[term_map_pkg::FAST_PULSE_TERM] &&
                       (sel_r[term_map_pkg::FAST_PULSE_TERM] == 6'(term_map_pkg::FN_PULSE_REF));

   // Request assembly; run inhibit gates every start-type request
   always_comb begin
      logic go_ok;
      logic fj;
      logic rj;
      go_ok = term_mode && !hits[term_map_pkg::FN_RUN_INHIBIT];
      fj = hits[term_map_pkg::FN_FWD_INCH];
      rj = hits[term_map_pkg::FN_REV_INCH];
      cmd_nxt = '0;
      cmd_nxt.forward_run_cmd = go_ok && hits[term_map_pkg::FN_FWD_RUN];
      cmd_nxt.reverse_run_cmd = go_ok && hits[term_map_pkg::FN_REV_RUN];
      cmd_nxt.forward_inch_cmd = go_ok && fj && !rj;
      cmd_nxt.reverse_inch_cmd = go_ok && rj && !fj;
      cmd_nxt.inch_stop = term_mode && fj && rj;
      cmd_nxt.three_wire = term_mode && hits[term_map_pkg::FN_THREE_WIRE];
      cmd_nxt.coast_stop = hits[term_map_pkg::FN_COAST];
      cmd_nxt.ext_stop = hits[term_map_pkg::FN_EXT_STOP];
      cmd_nxt.emerg_stop = hits[term_map_pkg::FN_EMERG];
      cmd_nxt.run_inhibit = hits[term_map_pkg::FN_RUN_INHIBIT];
      cmd_nxt.run_pause = hits[term_map_pkg::FN_RUN_PAUSE];
      cmd_nxt.external_fault_indication = hits[term_map_pkg::FN_EXT_FAULT];
      cmd_nxt.fault_reset = rise[term_map_pkg::FN_FAULT_RESET];
      cmd_nxt.updn_clear = hits[term_map_pkg::FN_UPDN_CLR];
      cmd_nxt.speed_index = hits[term_map_pkg::FN_STEP0 +: 4];
      cmd_nxt.accel_index = hits[term_map_pkg::FN_ACC0 +: 2];
      cmd_nxt.accel_hold = hits[term_map_pkg::FN_ACC_HOLD];
      cmd_nxt.ref_switch = hits[term_map_pkg::FN_REF_SWITCH];
      cmd_nxt.main_digital = hits[term_map_pkg::FN_MAIN_DIGITAL];
      cmd_nxt.aux_digital = hits[term_map_pkg::FN_AUX_DIGITAL];
      cmd_nxt.dcb_stop_cmd = hits[term_map_pkg::FN_DCB_STOP_CMD];
      cmd_nxt.dcb_stop = hits[term_map_pkg::FN_DCB_STOP];
      cmd_nxt.dcb_start = hits[term_map_pkg::FN_DCB_START];
      cmd_nxt.pulse_ref = hits[term_map_pkg::FN_PULSE_REF];
      cmd_nxt.pulse_ref_fast = fast_pulse;
      cmd_nxt.pid_invert = hits[term_map_pkg::FN_PID_INVERT];
      cmd_nxt.pid_gain2 = hits[term_map_pkg::FN_PID_GAIN2] &&
         (config_r[term_map_pkg::CFG_GAINSW_LSB +: 2] == term_map_pkg::GAIN_SWITCH_BY_TERM);
      cmd_nxt.pid_hold = hits[term_map_pkg::FN_PID_HOLD];
      cmd_nxt.pid_int_hold = hits[term_map_pkg::FN_PID_INT_HOLD];
      cmd_nxt.seq_reset = rise[term_map_pkg::FN_SEQ_RESET];
      cmd_nxt.seq_disable = hits[term_map_pkg::FN_SEQ_DISABLE];
      cmd_nxt.seq_restart = fall[term_map_pkg::FN_SEQ_DISABLE];
      cmd_nxt.cmd_src = src_nxt;
   end

   // Registered requests, one cycle behind the terminal levels
   always_ff @(posedge MCLK) begin
      if (!RST_N) begin
         cmd_r <= '0;
      end else begin
         cmd_r <= cmd_nxt;
      end
   end

   // Event counter; a count edge in the clear cycle survives as one
   always_ff @(posedge MCLK) begin
      if (!RST_N) begin
         event_r <= '0;
      end else if (hits[term_map_pkg::FN_COUNT_CLR]) begin
         event_r <= CNT_W'(rise[term_map_pkg::FN_COUNT_IN]);
      end else if (rise[term_map_pkg::FN_COUNT_IN]) begin
         event_r <= event_r + 1'b1;
      end
   end

   // Length accumulator, same clear behaviour as the event counter
   always_ff @(posedge MCLK) begin
      if (!RST_N) begin
         length_r <= '0;
      end else if (hits[term_map_pkg::FN_LENGTH_CLR]) begin
         length_r <= CNT_W'(rise[term_map_pkg::FN_LENGTH_IN]);
      end else if (rise[term_map_pkg::FN_LENGTH_IN]) begin
         length_r <= length_r + 1'b1;
      end
   end

   // Up/down trim steps one count per edge and saturates rather than wraps
   always_comb begin
      logic up;
      logic dn;
      up = updn_active && rise[term_map_pkg::FN_UP];
      dn = updn_active && rise[term_map_pkg::FN_DOWN];
      trim_nxt = trim_r;
      if (hits[term_map_pkg::FN_UPDN_CLR]) begin
         trim_nxt = '0;
      end
      if (up && !dn && trim_nxt != {1'b0, {(TRIM_W-1){1'b1}}}) begin
         trim_nxt = trim_nxt + TRIM_W'(1);
      end else if (dn && !up && trim_nxt != {1'b1, {(TRIM_W-1){1'b0}}}) begin
         trim_nxt = trim_nxt - TRIM_W'(1);
      end
   end

   always_ff @(posedge MCLK) begin
      if (!RST_N) begin
         trim_r <= '0;
      end else begin
         trim_r <= trim_nxt;
      end
   end

   // Wishbone classic slave: ack one cycle after the strobe, dropped next cycle
   assign bus_req = CYC_I && STB_I && !ack_r;
   // Writes commit while ack stands, at the edge where the master samples it
   assign bus_wr = CYC_I && STB_I && WE_I && ack_r;

   always_ff @(posedge MCLK) begin
      if (!RST_N) begin
         ack_r <= 1'b0;
      end else begin
         ack_r <= bus_req;
      end
   end

   // Selector writes; the write lands on the edge that ends the ack cycle
   always_ff @(posedge MCLK) begin
      if (!RST_N) begin
         for (int t = 0; t < term_map_pkg::NUM_TERMS; t++) begin
            sel_r[t] <= term_map_pkg::SEL_RESET[t];
         end
      end else if (bus_wr && SEL_I[0]) begin
         for (int t = 0; t < term_map_pkg::NUM_TERMS; t++) begin
            if (ADR_I[7:2] == 6'(t) + term_map_pkg::OFF_SEL_BASE[7:2]) begin
               sel_r[t] <= DAT_I[term_map_pkg::SEL_W-1:0];
            end
         end
      end
   end

   // Config register write; it steers source, gain switch and up/down channel
   always_ff @(posedge MCLK) begin
      if (!RST_N) begin
         config_r <= term_map_pkg::CONFIG_RESET;
      end else if (bus_wr && ADR_I[7:2] == term_map_pkg::OFF_CONFIG[7:2]) begin
         config_r <= 9'(merge_lanes({23'h0, config_r}, DAT_I, SEL_I));
      end
   end

   // Read data captured with the request; unmapped reads answer zero
   always_ff @(posedge MCLK) begin
      if (!RST_N) begin
         dat_r <= '0;
      end else if (bus_req && !WE_I) begin
         dat_r <= '0;
         if (ADR_I[7:2] < 6'(term_map_pkg::NUM_TERMS)) begin
            dat_r <= {26'h0, sel_r[ADR_I[5:2]]};
         end else begin
            case ({ADR_I[7:2], 2'b00})
               term_map_pkg::OFF_CONFIG: dat_r <= {23'h0, config_r};
               term_map_pkg::OFF_HITS_LO: dat_r <= hits[31:0];
               term_map_pkg::OFF_HITS_HI: dat_r <= hits[63:32];
               term_map_pkg::OFF_EVENT_CNT: dat_r <= 32'(event_r);
               term_map_pkg::OFF_LENGTH_CNT: dat_r <= 32'(length_r);
               term_map_pkg::OFF_UPDN_TRIM: dat_r <= 32'(trim_r);
               term_map_pkg::OFF_CMD_SRC: dat_r <= {30'h0, cmd_r.cmd_src};
               default: dat_r <= '0;
            endcase
         end
      end
   end

   // Outputs all come from flops
   assign ACK_O = ack_r;
   assign DAT_O = dat_r;
   assign CMD = cmd_r;
   assign EVENT_COUNT = event_r;
   assign LENGTH_COUNT = length_r;
   assign UPDN_TRIM = trim_r;

endmodule

// >>> tb/mapper_checker_properties.sv
// Purpose: Port-level checks on the terminal function mapper
// Assumes: One clock, synchronous active-low reset
// Notes: Selectors are not visible here, so every check holds for any mapping
module mapper_checker #(
   parameter int CNT_W = 32, // Counter width
   parameter int TRIM_W = 16 // Trim width
) (
   input wire logic MCLK, // Clock
   input wire logic RST_N, // Reset, active low
   input wire logic CYC_I, // Bus cycle
   input wire logic STB_I, // Bus strobe
   input wire logic WE_I, // Write enable
   input wire logic [7:0] ADR_I, // Address
   input wire logic [3:0] SEL_I, // Byte lanes
   input wire logic [31:0] DAT_I, // Write data
   input wire logic [31:0] DAT_O, // Read data
   input wire logic ACK_O, // Acknowledge
   input wire logic [term_map_pkg::NUM_TERMS-1:0] TERM_IN, // Terminal levels
   input wire term_map_pkg::req_t CMD, // Requests
   input wire logic [CNT_W-1:0] EVENT_COUNT, // Event total
   input wire logic [CNT_W-1:0] LENGTH_COUNT, // Length total
   input wire logic signed [TRIM_W-1:0] UPDN_TRIM // Trim
);
   // All checks share the system clock and its reset
   default clocking cb @(posedge MCLK); endclocking
   default disable iff (!RST_N);

   chk_ack_single: assert property (CYC_I && STB_I && !ACK_O |=> ACK_O ##1 !ACK_O)
      else $error("ack is not a single pulse");
   chk_idle_quiet: assert property ($past(TERM_IN) == '0 |-> CMD.speed_index == 4'h0
      && !(CMD.forward_run_cmd || CMD.coast_stop || CMD.run_inhibit || CMD.pid_hold))
      else $error("request with no terminal on");
   chk_inch_excl: assert property (CMD.forward_inch_cmd
      |-> !CMD.reverse_inch_cmd && !CMD.inch_stop)
      else $error("inch requests overlap");
   chk_src_gate: assert property (CMD.forward_run_cmd || CMD.reverse_run_cmd
      || CMD.forward_inch_cmd || CMD.reverse_inch_cmd |-> CMD.cmd_src == 2'h1)
      else $error("run request outside terminal source");
   chk_inhibit_run: assert property (CMD.run_inhibit
      |-> !CMD.forward_run_cmd && !CMD.reverse_run_cmd)
      else $error("run request while inhibited");
   chk_fault_pulse: assert property (CMD.fault_reset |=> !CMD.fault_reset)
      else $error("fault reset longer than a cycle");
   chk_seq_restart: assert property (CMD.seq_restart |-> $past(CMD.seq_disable) && !CMD.seq_disable)
      else $error("restart without disable release");
   chk_fast_pulse: assert property (CMD.pulse_ref_fast |-> CMD.pulse_ref && $past(TERM_IN[6]))
      else $error("fast pulse off the seventh terminal");
   chk_count_step: assert property ($changed(EVENT_COUNT) |->
      EVENT_COUNT == $past(EVENT_COUNT) + 1'b1 || EVENT_COUNT <= 1)
      else $error("event count jumped");
   chk_trim_step: assert property ($changed(UPDN_TRIM) |-> UPDN_TRIM inside {-1, 0, 1}
      || UPDN_TRIM - $past(UPDN_TRIM) == 1 || $past(UPDN_TRIM) - UPDN_TRIM == 1)
      else $error("trim moved more than one step");

   cov_fwd_run: cover property (CMD.forward_run_cmd);
   cov_fault_reset: cover property (CMD.fault_reset);
   cov_top_speed: cover property (CMD.speed_index == 4'hf);
endmodule

bind input_terminal_function_mapper mapper_checker #(.CNT_W(CNT_W), .TRIM_W(TRIM_W)) chk_i (
   .MCLK(MCLK), .RST_N(RST_N), .CYC_I(CYC_I), .STB_I(STB_I), .WE_I(WE_I), .ADR_I(ADR_I),
   .SEL_I(SEL_I), .DAT_I(DAT_I), .DAT_O(DAT_O), .ACK_O(ACK_O), .TERM_IN(TERM_IN), .CMD(CMD),
   .EVENT_COUNT(EVENT_COUNT), .LENGTH_COUNT(LENGTH_COUNT), .UPDN_TRIM(UPDN_TRIM));

// >>> tb/contact_bank.sv
// Purpose: Model of the switch contacts wired to the terminals
// Assumes: Contacts are already debounced
// Notes: A thrown contact reaches its terminal one cycle later
module contact_bank (
   input wire logic clk, // Bench clock
   input wire logic [9:0] closed, // Contacts the bench wants closed
   output logic [9:0] term_out // Levels at the terminals
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [9:0] level_r = 10'h000;

   // Open contacts read low, so nothing is left floating
   always @(posedge clk) begin
      level_r <= closed;
   end
   assign term_out = level_r;
endmodule

// >>> tb/tb_top.sv
// Purpose: Self-checking bench for the terminal function mapper
// Assumes: Bus answers within a few cycles
// Notes: Expected values come from the function code table only
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic MCLK = 1'b0;
   logic RST_N = 1'b0;
   logic CYC_I = 1'b0;
   logic STB_I = 1'b0;
   logic WE_I = 1'b0;
   logic [7:0] ADR_I = 8'h00;
   logic [3:0] SEL_I = 4'h0;
   logic [31:0] DAT_I = 32'h0;
   logic [31:0] DAT_O, EVENT_COUNT, LENGTH_COUNT, q;
   logic ACK_O;
   logic [9:0] TERM_IN;
   logic [9:0] closed = 10'h000;
   logic signed [15:0] UPDN_TRIM;
   term_map_pkg::req_t CMD;
   int err_count = 0;
   int check_count = 0;
   int codes[21] = '{5, 6, 7, 8, 9, 10, 11, 15, 22, 26, 27, 28, 29, 30, 31, 32,
                     37, 38, 39, 40, 42};

   // 20 MHz clock
   always #25 MCLK = ~MCLK;

   input_terminal_function_mapper uut (.MCLK(MCLK), .RST_N(RST_N), .CYC_I(CYC_I),
      .STB_I(STB_I), .WE_I(WE_I), .ADR_I(ADR_I), .SEL_I(SEL_I), .DAT_I(DAT_I), .DAT_O(DAT_O),
      .ACK_O(ACK_O), .TERM_IN(TERM_IN), .CMD(CMD), .EVENT_COUNT(EVENT_COUNT),
      .LENGTH_COUNT(LENGTH_COUNT), .UPDN_TRIM(UPDN_TRIM));
   contact_bank contacts (.clk(MCLK), .closed(closed), .term_out(TERM_IN));

   // Verdict and end of run
   task automatic end_sim();
      $display("checks %0d errors %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         err_count++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask

   // Classic single cycle; request held until ack is sampled
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge MCLK);
      {CYC_I, STB_I, WE_I, SEL_I, ADR_I, DAT_I} <= {2'b11, w, 4'hf, a, d};
      do begin
         @(posedge MCLK);
         n++;
      end while (ACK_O !== 1'b1 && n < 16);
      q = DAT_O;
      {CYC_I, STB_I} <= 2'b00;
      if (ACK_O !== 1'b1) begin
         err_count++;
         end_sim();
      end
   endtask

   task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
      wb(1'b0, a, 32'h0);
      chk(nm, e, q);
   endtask

   // Contact settles, then CMD follows one cycle later
   task automatic term(input logic [9:0] v);
      @(posedge MCLK);
      closed <= v;
      repeat (3) @(posedge MCLK);
   endtask

   function automatic logic fbit(input int c);
      case (c)
         5: return CMD.three_wire;
         6: return CMD.coast_stop;
         7: return CMD.emerg_stop;
         8: return CMD.ext_stop;
         9: return CMD.run_inhibit;
         10: return CMD.run_pause;
         11: return CMD.external_fault_indication;
         12: return CMD.fault_reset;
         15: return CMD.updn_clear;
         22: return CMD.accel_hold;
         26: return CMD.ref_switch;
         27: return CMD.main_digital;
         28: return CMD.aux_digital;
         29: return CMD.dcb_stop_cmd;
         30: return CMD.dcb_stop;
         31: return CMD.dcb_start;
         32: return CMD.pulse_ref;
         37: return CMD.pid_invert;
         38: return CMD.pid_gain2;
         39: return CMD.pid_hold;
         40: return CMD.pid_int_hold;
         41: return CMD.seq_reset;
         42: return CMD.seq_disable;
         default: return CMD.seq_restart;
      endcase
   endfunction

   // Pulses are counted over a window wider than the latency
   task automatic pulses(input string nm, input int c, input logic [9:0] v);
      int n;
      n = 0;
      @(posedge MCLK);
      closed <= v;
      repeat (5) begin
         @(posedge MCLK);
         n += fbit(c);
      end
      chk(nm, 1, n);
   endtask

   // Main sequence
   initial begin
      repeat (4) @(posedge MCLK);
      RST_N <= 1'b1;
      for (int t = 0; t < 10; t++) begin
         rdc("sel reset", 8'(t * 4), 32'(term_map_pkg::SEL_RESET[t]));
      end
      rdc("config reset", term_map_pkg::OFF_CONFIG, 32'h001);
      rdc("unmapped", 8'hfc, 32'h0);
      term(10'h001);
      chk("fwd run", 1, CMD.forward_run_cmd);
      term(10'h002);
      chk("rev run", 1, CMD.reverse_run_cmd);
      wb(1'b1, term_map_pkg::OFF_CONFIG, 32'h0);
      term(10'h002);
      chk("run gated", 0, CMD.reverse_run_cmd);
      wb(1'b1, term_map_pkg::OFF_CONFIG, 32'h181);
      wb(1'b1, 8'h00, 32'h3);
      wb(1'b1, 8'h04, 32'h4);
      for (int v = 1; v < 4; v++) begin
         term(10'(v));
         chk("inch fwd", v == 1, CMD.forward_inch_cmd);
         chk("inch rev", v == 2, CMD.reverse_inch_cmd);
         chk("inch stop", v == 3, CMD.inch_stop);
      end
      wb(1'b1, term_map_pkg::OFF_CONFIG, 32'h182);
      for (int c = 23; c < 26; c++) begin
         wb(1'b1, 8'h08, c);
         term(10'h005);
         chk("src", c - 23, CMD.cmd_src);
         chk("src gate", c == 24, CMD.forward_inch_cmd);
         rdc("src reg", term_map_pkg::OFF_CMD_SRC, c - 23);
      end
      wb(1'b1, term_map_pkg::OFF_CONFIG, 32'h181);
      wb(1'b1, 8'h08, 32'h10);
      wb(1'b1, 8'h14, 32'h13);
      for (int i = 0; i < 16; i++) begin
         term(10'(i << 2));
         chk("speed", i, CMD.speed_index);
      end
      wb(1'b1, 8'h00, 32'h14);
      wb(1'b1, 8'h04, 32'h15);
      for (int i = 0; i < 4; i++) begin
         term(10'(i));
         chk("accel", i, CMD.accel_index);
      end
      wb(1'b1, 8'h00, 32'h1);
      for (int k = 0; k < 21; k++) begin
         wb(1'b1, 8'h1c, codes[k]);
         wb(1'b1, 8'h20, codes[k]);
         rdc("sel rw", 8'h1c, codes[k]);
         term(10'h080);
         chk("level on", 1, fbit(codes[k]));
         term(10'h100);
         chk("or on", 1, fbit(codes[k]));
         term(10'h000);
         chk("level off", 0, fbit(codes[k]));
      end
      term(10'h080);
      pulses("restart", 99, 10'h000);
      wb(1'b1, 8'h1c, 32'h9);
      term(10'h081);
      chk("inhibit", 0, CMD.forward_run_cmd);
      wb(1'b1, 8'h1c, 32'h0);
      term(10'h081);
      chk("none", 1, CMD[37:2] === 36'h800000000 && CMD.forward_run_cmd);
      rdc("hits lo", term_map_pkg::OFF_HITS_LO, 32'h2);
      wb(1'b1, 8'h1c, 32'hc);
      pulses("fault reset", 12, 10'h080);
      wb(1'b1, 8'h1c, 32'h29);
      pulses("seq reset", 41, 10'h000);
      pulses("seq reset", 41, 10'h080);
      wb(1'b1, 8'h18, 32'h20);
      term(10'h040);
      chk("fast pulse", 1, CMD.pulse_ref_fast);
      rdc("hits hi", term_map_pkg::OFF_HITS_HI, 32'h1);
      wb(1'b1, 8'h1c, 32'h20);
      term(10'h080);
      chk("slow pulse", 0, CMD.pulse_ref_fast);
      for (int k = 0; k < 2; k++) begin
         wb(1'b1, 8'h1c, 33 + 2 * k);
         wb(1'b1, 8'h20, 34 + 2 * k);
         for (int i = 0; i < 3; i++) begin
            term(10'h080);
            term(10'h000);
         end
         chk("count", 3, k ? LENGTH_COUNT : EVENT_COUNT);
         rdc("count reg", k ? term_map_pkg::OFF_LENGTH_CNT : term_map_pkg::OFF_EVENT_CNT, 3);
         term(10'h100);
         chk("count clear", 0, k ? LENGTH_COUNT : EVENT_COUNT);
      end
      term(10'h000);
      wb(1'b1, 8'h1c, 32'hd);
      wb(1'b1, 8'h20, 32'he);
      wb(1'b1, 8'h24, 32'hf);
      for (int i = 0; i < 3; i++) begin
         term(i == 2 ? 10'h100 : 10'h080);
         term(10'h000);
      end
      chk("trim", 1, 32'(UPDN_TRIM));
      rdc("trim reg", term_map_pkg::OFF_UPDN_TRIM, 32'h1);
      term(10'h200);
      chk("trim clear", 0, 32'(UPDN_TRIM));
      end_sim();
   end
endmodule
